//--- rtl/dtc_consts.vh
`ifndef DTC_CONSTS_VH
`define DTC_CONSTS_VH
// byte addresses of the word registers
`define DTC_ADDR_CTRL 8'h00
`define DTC_ADDR_MODE 8'h04
`define DTC_ADDR_T0L 8'h08
`define DTC_ADDR_T1L 8'h0C
`define DTC_ADDR_T0H 8'h10
`define DTC_ADDR_T1H 8'h14
`define DTC_ADDR_SVC 8'h18
// control register bit positions
`define DTC_CTRL_EXT0_TYPE 0
`define DTC_CTRL_EXT0_FLAG 1
`define DTC_CTRL_EXT1_TYPE 2
`define DTC_CTRL_EXT1_FLAG 3
`define DTC_CTRL_RUN0 4
`define DTC_CTRL_OVF0 5
`define DTC_CTRL_RUN1 6
`define DTC_CTRL_OVF1 7
// mode register field positions (timer 1 uses these plus 4)
`define DTC_MODE_LO 0
`define DTC_MODE_HI 1
`define DTC_MODE_SRC 2
`define DTC_MODE_GATE 3
`define DTC_T1_SHIFT 4
// mode encodings
`define DTC_M13 2'h0
`define DTC_M16 2'h1
`define DTC_M8AR 2'h2
`define DTC_M3 2'h3
`define DTC_RST_BYTE 8'h00
// peripheral cycle length in clock periods
`define DTC_PER_DIV 6
`define DTC_DIV_W 3
`endif

//--- rtl/dtc_dual_timer_counter.v
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`include "dtc_consts.vh"
`default_nettype none
//Function
//- low byte carries into high byte, overflow flags
//- run bit enables counting, keeps count
//- timer source counts every six clocks
//- counter source counts sampled falling edges
//- edge recognition takes two peripheral cycles
//- gate bit adds gate pin control
//- gated timer counts only while pin high
//- rollover sets overflow flag, raises request
//- mode 0 is 5-bit prescaler plus byte
//- mode 1 is full 16-bit counter
//- mode 2 reloads low from high byte
//- servicing request clears overflow flag
//- timer 0 mode 3 splits two bytes
//- timer 1 mode 3 holds count
//- control and mode bit assignment per timer
//- timer 0 mode 3 borrows timer 1 controls
//- timer 1 overflow gives baud tick; a mode 2 reload of FF gives none
//- mode field encodings 00 to 11
//- all registers reset to zero
module dtc_dual_timer_counter (
   input wire i_clk_sys,
   input wire i_rst,
   input wire [31:0] i_haddr,
   input wire [1:0] i_htrans,
   input wire i_hwrite,
   input wire [2:0] i_hsize,
   input wire [31:0] i_hwdata,
   input wire i_hsel,
   input wire i_hready,
   output reg [31:0] o_hrdata,
   output reg o_hreadyout,
   output reg o_hresp,
   input wire i_count_pin_zero,
   input wire i_count_pin_one,
   input wire i_gate_pin_zero_n,
   input wire i_gate_pin_one_n,
   input wire i_irq_ack0,
   input wire i_irq_ack1,
   output reg o_irq_req0,
   output reg o_irq_req1,
   output reg o_baud_tick
);
   reg [7:0] timer_control_register;
   reg [7:0] timer_mode_register;
   reg [7:0] timer0_low_byte;
   reg [7:0] timer0_high_byte;
   reg [7:0] timer1_low_byte;
   reg [7:0] timer1_high_byte;
   reg [`DTC_DIV_W-1:0] div_reg;
   reg per_en_reg;
   reg [3:0] sync1_reg;
   reg [3:0] sync2_reg;
   reg [1:0] cnt_sample_reg;
   reg wr_pend_reg;
   reg [7:0] wr_addr_reg;
   reg [7:0] ctrl_next;
   reg [7:0] t0l_next;
   reg [7:0] t0h_next;
   reg [7:0] t1l_next;
   reg [7:0] t1h_next;
   reg ovf0;
   reg ovf1;
   reg [8:0] sum;
   wire [1:0] mode0;
   wire [1:0] mode1;
   wire run0;
   wire run1;
   wire inc0;
   wire inc1;
   wire inc_split;
   wire t0_split;
   wire addr_ok;

   // selected source pulse: tick or sampled falling edge, gated
   function src_pulse;
      input run;
      input gate;
      input src;
      input gate_pin_hi;
      input prev_sample;
      input cur_sample;
      input en;
      begin
         if (!en || !run || (gate && !gate_pin_hi)) begin
            src_pulse = 1'b0;
         end else if (src) begin
            src_pulse = prev_sample & ~cur_sample;
         end else begin
            src_pulse = 1'b1;
         end
      end
   endfunction

   assign mode0 = {timer_mode_register[`DTC_MODE_HI], timer_mode_register[`DTC_MODE_LO]};
   assign mode1 = {timer_mode_register[`DTC_MODE_HI + `DTC_T1_SHIFT],
      timer_mode_register[`DTC_MODE_LO + `DTC_T1_SHIFT]};
   assign run0 = timer_control_register[`DTC_CTRL_RUN0];
   assign run1 = timer_control_register[`DTC_CTRL_RUN1];
   assign t0_split = (mode0 == `DTC_M3);
   assign inc0 = src_pulse(run0, timer_mode_register[`DTC_MODE_GATE], timer_mode_register[`DTC_MODE_SRC],
      sync2_reg[2], cnt_sample_reg[0], sync2_reg[0], per_en_reg);
   assign inc1 = src_pulse(run1, timer_mode_register[`DTC_MODE_GATE + `DTC_T1_SHIFT],
      timer_mode_register[`DTC_MODE_SRC + `DTC_T1_SHIFT], sync2_reg[3], cnt_sample_reg[1], sync2_reg[1],
      per_en_reg);
   // high byte of timer 0 takes run bit 1
   assign inc_split = per_en_reg & run1;
   assign addr_ok = (i_haddr[1:0] == 2'h0);

   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         div_reg <= {`DTC_DIV_W{1'b0}};
         per_en_reg <= 1'b0;
      end else if (div_reg == `DTC_PER_DIV - 1) begin
         div_reg <= {`DTC_DIV_W{1'b0}};
         per_en_reg <= 1'b1;
      end else begin
         div_reg <= div_reg + 1'b1;
         per_en_reg <= 1'b0;
      end
   end

   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         sync1_reg <= 4'h0;
         sync2_reg <= 4'h0;
         cnt_sample_reg <= 2'h0;
      end else begin
         sync1_reg <= {i_gate_pin_one_n, i_gate_pin_zero_n, i_count_pin_one, i_count_pin_zero};
         sync2_reg <= sync1_reg;
         if (per_en_reg) begin
            cnt_sample_reg <= sync2_reg[1:0];
         end
      end
   end

   // counting datapath
   always @* begin
      t0l_next = timer0_low_byte;
      t0h_next = timer0_high_byte;
      t1l_next = timer1_low_byte;
      t1h_next = timer1_high_byte;
      ovf0 = 1'b0;
      ovf1 = 1'b0;
      sum = 9'h000;
      if (inc0) begin
         case (mode0)
            `DTC_M13: begin
               t0l_next = {timer0_low_byte[7:5], timer0_low_byte[4:0] + 5'h01};
               if (timer0_low_byte[4:0] == 5'h1F) begin
                  sum = {1'b0, timer0_high_byte} + 9'h001;
                  t0h_next = sum[7:0];
                  ovf0 = sum[8];
               end
            end
            `DTC_M16: begin
               t0l_next = timer0_low_byte + 8'h01;
               if (timer0_low_byte == 8'hFF) begin
                  sum = {1'b0, timer0_high_byte} + 9'h001;
                  t0h_next = sum[7:0];
                  ovf0 = sum[8];
               end
            end
            `DTC_M8AR: begin
               if (timer0_low_byte == 8'hFF) begin
                  t0l_next = timer0_high_byte;
                  ovf0 = 1'b1;
               end else begin
                  t0l_next = timer0_low_byte + 8'h01;
               end
            end
            default: begin
               t0l_next = timer0_low_byte + 8'h01;
               ovf0 = (timer0_low_byte == 8'hFF);
            end
         endcase
      end
      // high byte counts ticks, flags timer 1
      if (t0_split && inc_split) begin
         t0h_next = timer0_high_byte + 8'h01;
         ovf1 = (timer0_high_byte == 8'hFF);
      end
      // timer 1 runs without run bit while split
      if ((t0_split ? src_pulse(1'b1, timer_mode_register[`DTC_MODE_GATE + `DTC_T1_SHIFT],
            timer_mode_register[`DTC_MODE_SRC + `DTC_T1_SHIFT], sync2_reg[3], cnt_sample_reg[1],
            sync2_reg[1], per_en_reg) : inc1)) begin
         case (mode1)
            `DTC_M13: begin
               t1l_next = {timer1_low_byte[7:5], timer1_low_byte[4:0] + 5'h01};
               if (timer1_low_byte[4:0] == 5'h1F) begin
                  sum = {1'b0, timer1_high_byte} + 9'h001;
                  t1h_next = sum[7:0];
                  ovf1 = ovf1 | (sum[8] & ~t0_split);
               end
            end
            `DTC_M16: begin
               t1l_next = timer1_low_byte + 8'h01;
               if (timer1_low_byte == 8'hFF) begin
                  sum = {1'b0, timer1_high_byte} + 9'h001;
                  t1h_next = sum[7:0];
                  ovf1 = ovf1 | (sum[8] & ~t0_split);
               end
            end
            `DTC_M8AR: begin
               if (timer1_low_byte == 8'hFF) begin
                  t1l_next = timer1_high_byte;
                  ovf1 = ovf1 | ~t0_split;
               end else begin
                  t1l_next = timer1_low_byte + 8'h01;
               end
            end
            default: begin
               t1l_next = timer1_low_byte;
            end
         endcase
      end
   end

   // baud tick on timer 1 rollover except a mode 2 reload of FF, also while split
   wire t1_roll;
   assign t1_roll = (t1l_next != timer1_low_byte) && (mode1 != `DTC_M3) &&
      (((mode1 == `DTC_M8AR) && (timer1_low_byte == 8'hFF)) ||
      ((mode1 != `DTC_M8AR) && (t1h_next == 8'h00) && (timer1_high_byte == 8'hFF)));

   // control register next value, flag set beats clear
   always @* begin
      ctrl_next = timer_control_register;
      if (wr_pend_reg && (wr_addr_reg == `DTC_ADDR_CTRL)) begin
         ctrl_next = i_hwdata[7:0];
      end
      if (i_irq_ack0) begin
         ctrl_next[`DTC_CTRL_OVF0] = 1'b0;
      end
      if (i_irq_ack1) begin
         ctrl_next[`DTC_CTRL_OVF1] = 1'b0;
      end
      if (ovf0) begin
         ctrl_next[`DTC_CTRL_OVF0] = 1'b1;
      end
      if (ovf1) begin
         ctrl_next[`DTC_CTRL_OVF1] = 1'b1;
      end
   end

   // register file and counters
   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         timer_control_register <= `DTC_RST_BYTE;
         timer_mode_register <= `DTC_RST_BYTE;
         timer0_low_byte <= `DTC_RST_BYTE;
         timer0_high_byte <= `DTC_RST_BYTE;
         timer1_low_byte <= `DTC_RST_BYTE;
         timer1_high_byte <= `DTC_RST_BYTE;
         o_irq_req0 <= 1'b0;
         o_irq_req1 <= 1'b0;
         o_baud_tick <= 1'b0;
      end else begin
         timer_control_register <= ctrl_next;
         timer0_low_byte <= t0l_next;
         timer0_high_byte <= t0h_next;
         timer1_low_byte <= t1l_next;
         timer1_high_byte <= t1h_next;
         if (wr_pend_reg) begin
            case (wr_addr_reg)
               `DTC_ADDR_MODE: timer_mode_register <= i_hwdata[7:0];
               `DTC_ADDR_T0L: timer0_low_byte <= i_hwdata[7:0];
               `DTC_ADDR_T1L: timer1_low_byte <= i_hwdata[7:0];
               `DTC_ADDR_T0H: timer0_high_byte <= i_hwdata[7:0];
               `DTC_ADDR_T1H: timer1_high_byte <= i_hwdata[7:0];
               default: begin
               end
            endcase
         end
         o_irq_req0 <= ctrl_next[`DTC_CTRL_OVF0];
         o_irq_req1 <= ctrl_next[`DTC_CTRL_OVF1];
         o_baud_tick <= t1_roll;
      end
   end

   // ahb-lite slave: zero wait, always okay
   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         o_hrdata <= 32'h00000000;
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end else begin
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
         wr_pend_reg <= 1'b0;
         if (i_hsel && i_hready && i_htrans[1] && addr_ok) begin
            wr_pend_reg <= i_hwrite;
            wr_addr_reg <= i_haddr[7:0];
            if (!i_hwrite) begin
               case (i_haddr[7:0])
                  `DTC_ADDR_CTRL: o_hrdata <= {24'h000000, timer_control_register};
                  `DTC_ADDR_MODE: o_hrdata <= {24'h000000, timer_mode_register};
                  `DTC_ADDR_T0L: o_hrdata <= {24'h000000, timer0_low_byte};
                  `DTC_ADDR_T1L: o_hrdata <= {24'h000000, timer1_low_byte};
                  `DTC_ADDR_T0H: o_hrdata <= {24'h000000, timer0_high_byte};
                  `DTC_ADDR_T1H: o_hrdata <= {24'h000000, timer1_high_byte};
                  default: o_hrdata <= 32'h00000000;
               endcase
               // a write still in its data phase is read back directly
               if (wr_pend_reg && (wr_addr_reg == i_haddr[7:0]) && (wr_addr_reg <= `DTC_ADDR_T1H)) begin
                  o_hrdata <= {24'h000000, i_hwdata[7:0]};
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- sim/dtc_dual_timer_counter_sva.sv
`default_nettype none
module dtc_chk (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic i_hsel,
   input wire logic i_hready,
   input wire logic [31:0] o_hrdata,
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   input wire logic i_irq_ack0,
   input wire logic i_irq_ack1,
   input wire logic o_irq_req0,
   input wire logic o_irq_req1,
   input wire logic o_baud_tick
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wr_q;
   // a write lands at the end of its data phase
   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) wr_q <= 1'b0;
      else wr_q <= i_hsel && i_hready && i_htrans[1] && i_hwrite;
   end
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   sequence rd_addr;
      i_hsel && i_hready && i_htrans[1] && !i_hwrite;
   endsequence
   sequence tick_gap;
      !o_baud_tick [*5];
   endsequence
   chk_bus_okay: assert property (o_hreadyout && !o_hresp)
      else $error("bus answer not ready or not okay");
   chk_reset_idle: assert property ($fell(i_rst) |-> !o_irq_req0 && !o_irq_req1 && !o_baud_tick)
      else $error("outputs active after reset");
   chk_ack_clear0: assert property (i_irq_ack0 |=> !o_irq_req0)
      else $error("request 0 kept after service");
   chk_ack_clear1: assert property (i_irq_ack1 |=> !o_irq_req1)
      else $error("request 1 kept after service");
   chk_tick_gap: assert property (o_baud_tick |=> tick_gap)
      else $error("baud ticks too close");
   chk_read_upper: assert property (rd_addr |=> o_hrdata[31:8] == 24'h000000)
      else $error("read data upper bits set");
   chk_req_hold0: assert property (o_irq_req0 && !i_irq_ack0 && !wr_q |=> o_irq_req0)
      else $error("request 0 dropped unserviced");
   chk_req_hold1: assert property (o_irq_req1 && !i_irq_ack1 && !wr_q |=> o_irq_req1)
      else $error("request 1 dropped unserviced");
endmodule
bind dtc_dual_timer_counter dtc_chk u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_htrans(i_htrans),
   .i_hwrite(i_hwrite), .i_hsel(i_hsel), .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
   .o_hresp(o_hresp), .i_irq_ack0(i_irq_ack0), .i_irq_ack1(i_irq_ack1), .o_irq_req0(o_irq_req0),
   .o_irq_req1(o_irq_req1), .o_baud_tick(o_baud_tick));
`default_nettype wire

//--- sim/dtc_pin_model.sv
`default_nettype none
module dtc_pin_model (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [1:0] i_en,
   input wire logic [4:0] i_half,
   input wire logic [1:0] i_gate,
   output logic o_cnt0,
   output logic o_cnt1,
   output logic o_timer0_gate_enable_n,
   output logic o_timer1_gate_enable_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] ph;
   // each level held half a period, i_half clocks
   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst || i_en == 2'h0) ph <= 6'h00;
      else if (ph == {i_half, 1'b0} - 6'h01) ph <= 6'h00;
      else ph <= ph + 6'h01;
   end
   // pins idle high, one falling edge per period
   assign o_cnt0 = !(i_en[0] && ph >= {1'b0, i_half});
   assign o_cnt1 = !(i_en[1] && ph >= {1'b0, i_half});
   assign o_timer0_gate_enable_n = i_gate[0];
   assign o_timer1_gate_enable_n = i_gate[1];
endmodule
`default_nettype wire

//--- sim/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, hwrite, hsel, ack0, ack1;
   logic [31:0] haddr, hwdata, q;
   logic [1:0] htrans, pen, gate;
   logic [2:0] hsize;
   logic [4:0] half;
   logic [15:0] v, v0;
   wire [31:0] hrdata;
   wire hready, hresp, req0, req1, tick, c0, c1, g0, g1;
   int n_fail = 0, n_compared = 0, cyc = 0, ticks = 0, t0, k, s;
   dtc_dual_timer_counter uut (.i_clk_sys(clk), .i_rst(rst), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hsel(hsel), .i_hready(hready),
      .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_count_pin_zero(c0),
      .i_count_pin_one(c1), .i_gate_pin_zero_n(g0), .i_gate_pin_one_n(g1), .i_irq_ack0(ack0),
      .i_irq_ack1(ack1), .o_irq_req0(req0), .o_irq_req1(req1), .o_baud_tick(tick));
   dtc_pin_model pm (.i_clk_sys(clk), .i_rst(rst), .i_en(pen), .i_half(half), .i_gate(gate),
      .o_cnt0(c0), .o_cnt1(c1), .o_timer0_gate_enable_n(g0), .o_timer1_gate_enable_n(g1));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (tick === 1'b1) ticks <= ticks + 1;
      if (cyc > 20000) begin
         n_fail++;
         stop_test();
      end
   end
   task stop_test();
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task xf(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      hsel <= 1'b1; haddr <= {24'h000000, a}; hwrite <= w; htrans <= 2'h2;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0; hwdata <= {24'h000000, d};
      do @(posedge clk); while (hready !== 1'b1);
      q = hrdata; t0 = cyc;
   endtask
   task ck(input string n, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++; $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task rg(input string n, input int lo, input int hi, input logic [15:0] g);
      n_compared++;
      if ((g >= lo && g <= hi) !== 1'b1) begin
         n_fail++; $display("[FAIL] %s expected %0d..%0d seen %0d", n, lo, hi, g);
      end
   endtask
   task run(input logic [7:0] c, input int n);
      xf(1, 8'h00, c); k = t0;
      repeat (n) @(posedge clk);
      xf(1, 8'h00, 8'h00); k = (t0 - k) / 6;
   endtask
   task get(input logic [7:0] al, input logic [7:0] ah);
      xf(0, ah, 8'h00); v[15:8] = q[7:0];
      xf(0, al, 8'h00); v[7:0] = q[7:0];
   endtask
   task load(input logic [7:0] al, input logic [7:0] l, input logic [7:0] h, input logic [7:0] m);
      xf(1, al, l); xf(1, al + 8'h08, h); xf(1, 8'h04, m);
   endtask
   initial begin
      rst = 1'b1; hwrite = 1'b0; hsel = 1'b0; ack0 = 1'b0; ack1 = 1'b0; haddr = '0; hwdata = '0;
      htrans = 2'h0; hsize = 3'h2; pen = 2'h0; gate = 2'h3; half = 5'h06;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a <= 24; a += 4) begin
         xf(0, a[7:0], 8'h00); ck("reset value", 16'h0000, q[15:0]);
      end
      $display("reset test done");
      load(8'h08, 8'hFC, 8'h12, 8'h01);
      run(8'h10, 60); get(8'h08, 8'h10); rg("mode1 count", 16'h12FC + k, 16'h12FD + k, v);
      load(8'h08, 8'h1E, 8'h00, 8'h00);
      run(8'h10, 24); get(8'h08, 8'h10); ck("mode0 high", 16'h0001, {8'h00, v[15:8]});
      rg("mode0 prescale", k - 2, k - 1, {11'h000, v[4:0]});
      load(8'h08, 8'hFE, 8'hF0, 8'h02); xf(1, 8'h00, 8'h10);
      for (int i = 0; i < 100 && req0 !== 1'b1; i++) @(posedge clk);
      xf(1, 8'h00, 8'h20); ck("request 0", 16'h0001, {15'h0000, req0});
      get(8'h08, 8'h10); ck("reload high", 16'h00F0, {8'h00, v[15:8]}); rg("reload low", 16'hF0, 16'hF8, v[7:0]);
      xf(0, 8'h00, 8'h00); ck("flag set", 16'h0020, q[15:0]);
      @(posedge clk); ack0 <= 1'b1; ack1 <= 1'b1;
      @(posedge clk); ack0 <= 1'b0; ack1 <= 1'b0;
      xf(0, 8'h00, 8'h00); ck("flag serviced", 16'h0000, q[15:0]);
      $display("mode test done");
      load(8'h08, 8'h00, 8'h00, 8'h99); load(8'h0C, 8'h00, 8'h00, 8'h99); gate <= 2'h0;
      run(8'h50, 48); get(8'h08, 8'h10); ck("gated low", 16'h0000, v);
      get(8'h0C, 8'h14); ck("gated low 1", 16'h0000, v);
      gate <= 2'h3;
      run(8'h50, 48); get(8'h08, 8'h10); rg("gated high", k, k + 1, v);
      get(8'h0C, 8'h14); rg("gated high 1", k, k + 1, v);
      for (int i = 0; i < 2; i++) begin
         load(8'h08, 8'h00, 8'h00, 8'h55); load(8'h0C, 8'h00, 8'h00, 8'h55);
         half <= i ? 5'h0F : 5'h06; xf(1, 8'h00, 8'h50);
         repeat (12) @(posedge clk);
         pen <= 2'h3;
         repeat (8 * half) @(posedge clk);
         pen <= 2'h0;
         repeat (30) @(posedge clk);
         xf(1, 8'h00, 8'h00);
         get(8'h08, 8'h10); ck("edges 0", 16'h0004, v);
         get(8'h0C, 8'h14); ck("edges 1", 16'h0004, v);
      end
      $display("counter test done");
      load(8'h08, 8'h00, 8'h00, 8'h03);
      run(8'h40, 60); get(8'h08, 8'h10); ck("split low", 16'h0000, {8'h00, v[7:0]});
      rg("split high", k, k + 1, {8'h00, v[15:8]});
      load(8'h0C, 8'hFE, 8'hFE, 8'h20); s = ticks;
      run(8'h40, 120); rg("baud ticks", k / 2 - 1, k / 2 + 1, ticks - s);
      xf(1, 8'h04, 8'h30); get(8'h0C, 8'h14); v0 = v; s = ticks;
      run(8'h40, 60); get(8'h0C, 8'h14); ck("halt count", v0, v); ck("halt ticks", 16'h0000, ticks - s);
      xf(1, 8'h00, 8'h80); @(posedge clk); ck("request 1", 16'h0001, {15'h0000, req1});
      ack1 <= 1'b1; @(posedge clk); ack1 <= 1'b0;
      xf(0, 8'h00, 8'h00); ck("flag 1 serviced", 16'h0000, q[15:0]);
      $display("timer 1 test done");
      rst <= 1'b1; @(posedge clk); rst <= 1'b0;
      get(8'h0C, 8'h14); ck("count after reset", 16'h0000, v);
      xf(0, 8'h04, 8'h00); ck("mode after reset", 16'h0000, q[15:0]);
      $display("second reset test done");
      stop_test();
   end
endmodule
`default_nettype wire
